// *** core/write_protect_pkg.sv ***
// package for the flash write-protection block
// assumes a single 20 MHz core clock and an apb master
package write_protect_pkg;
   localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
   localparam logic [7:0] CMD_WRITE_LATCH_CLR = 8'h04;
   localparam logic [7:0] CMD_VOLATILE_SR_EN = 8'h50;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hc7;
   localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] CMD_FUNC_WRITE = 8'h42;
   localparam logic [7:0] CMD_VOL_PARAM_ALT = 8'hc0;
   localparam logic [7:0] CMD_VOL_BANK_ALT = 8'h17;
   localparam logic [7:0] CMD_VOL_PARAM = 8'h63;
   localparam logic [7:0] CMD_VOL_BANK = 8'hc5;
   // apb map
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_COMMAND = 8'h04;
   localparam logic [7:0] ADDR_TARGET = 8'h08;
   localparam logic [7:0] ADDR_CONFIG = 8'h0c;
   localparam logic [7:0] ADDR_RESULT = 8'h10;
   localparam logic [7:0] ADDR_RANGE = 8'h14;
   // status fields
   localparam int SR_LATCH = 1;
   localparam int SR_CODE_LO = 2;
   localparam int SR_QUAD = 6;
   localparam int SR_LOCK = 7;
   localparam logic [7:0] SR_WRITABLE_MASK = 8'hfc;
   localparam logic [7:0] SR_RESET = 8'h00;
   // config fields
   localparam int CFG_TOP_BOTTOM = 0;
   localparam int CFG_BIG_BLOCK = 1;
   // result fields
   localparam int RES_DONE = 0;
   localparam int RES_ACCEPTED = 1;
   localparam int RES_PROTECTED = 2;
   localparam int RES_NO_LATCH = 3;
   localparam int RES_LOCKED = 4;
   // geometry
   localparam logic [10:0] BLOCKS_SMALL = 11'd1024;
   localparam logic [10:0] BLOCKS_BIG = 11'd256;
   localparam int ADDR_W = 26;
   localparam int SMALL_SHIFT = 16;
   localparam int BIG_SHIFT = 18;
   localparam logic [3:0] CODE_FULL_BIG = 4'h9;
   localparam logic [3:0] CODE_LAST_SINGLE = 4'h9;
   localparam int CMD_DATA_LO = 8;
   localparam int PARAM_RESET_SEL = 7;
   localparam int PIN_TWO = 0;
   localparam int PIN_THREE = 1;
   typedef enum logic [1:0] {OP_NONE, OP_PROGRAM, OP_NVWRITE, OP_OTHER} op_class_type;
endpackage : write_protect_pkg

// *** core/flash_block_write_protection.sv ***
// flash block write-protection with command gating and apb registers
// assumes commands arrive as apb writes; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - volatile status write happens only right after the volatile-enable command
// - alternate volatile param and bank commands need no write latch
// - protect code selects region; program or erase inside it inhibited
// - whole chip erase ignored unless protect code is zero
// - lock bit zero lets status writes through regardless of protect pin
// - lock set and pin low: lock, quad, code read-only, write ignored
// - lock set and pin high: status write still allowed
// - quad zero: shared pins are protect input and hold/reset input
// - quad one: shared pins become data lines two and three
// - 64KB codes 0..9 protect none then 1..256 blocks from selected end
// - 64KB codes 10..15 protect 512,768,896,960,992,1024 blocks
// - 256KB codes 0..8 protect none to 128 blocks; 9 upward all
// - top/bottom select defaults top; once bottom it stays bottom
// - program, erase, nv writes need latch; latch clears on completion
module flash_block_write_protection
   import write_protect_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic shared_pin_two_in,
   input wire logic shared_pin_three_in,
   output logic shared_pin_two_out,
   output logic shared_pin_two_oe,
   output logic shared_pin_three_out,
   output logic shared_pin_three_oe,
   input wire logic [1:0] quad_data_out,
   input wire logic [1:0] quad_data_oe,
   output logic [1:0] quad_data_in,
   output logic hold_active,
   output logic reset_request
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [10:0] protected_count(input logic [3:0] code, input logic big);
      logic [10:0] n;
      n = 11'd0;
      if (big) begin
         if (code >= CODE_FULL_BIG) begin
            n = BLOCKS_BIG;
         end else if (code != 4'h0) begin
            n = 11'(11'd1 << (code - 4'h1));
         end
      end else begin
         case (code)
            4'ha, 4'hb, 4'hc, 4'hd, 4'he: n = BLOCKS_SMALL - (BLOCKS_SMALL >> (code - CODE_LAST_SINGLE));
            4'hf: n = BLOCKS_SMALL;
            4'h0: n = 11'd0;
            default: n = 11'(11'd1 << (code - 4'h1));
         endcase
      end
      return n;
   endfunction : protected_count

   function automatic logic in_region(input logic [ADDR_W-1:0] addr, input logic [3:0] code,
         input logic big, input logic bottom);
      logic [10:0] blk;
      logic [10:0] n;
      logic [10:0] total;
      blk = big ? 11'(addr >> BIG_SHIFT) : 11'(addr >> SMALL_SHIFT);
      n = protected_count(code, big);
      total = big ? BLOCKS_BIG : BLOCKS_SMALL;
      if (bottom) begin
         in_region = blk < n;
      end else begin
         in_region = blk >= (total - n);
      end
      if (n == 11'd0) begin
         in_region = 1'b0;
      end
   endfunction : in_region

   function automatic logic write_hit(input logic sel, input logic en, input logic wr,
         input logic [7:0] addr, input logic [7:0] target);
      return sel && en && wr && (addr == target);
   endfunction : write_hit

   function automatic logic addr_mapped(input logic [7:0] addr);
      case (addr)
         ADDR_STATUS, ADDR_COMMAND, ADDR_TARGET, ADDR_CONFIG, ADDR_RESULT, ADDR_RANGE: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : addr_mapped

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_meta_r <= 2'b11;
      end else begin
         pin_meta_r <= {shared_pin_three_in, shared_pin_two_in};
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_sync_r <= 2'b11;
      end else begin
         pin_sync_r <= pin_meta_r;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] status_r;
   logic bottom_r;
   logic big_r;
   logic vol_enable_r;
   logic [ADDR_W-1:0] target_r;
   logic [4:0] result_r;
   logic [7:0] vol_param_r;

   wire logic [3:0] code = status_r[SR_CODE_LO +: 4];
   wire logic quad = status_r[SR_QUAD];
   wire logic protect_pin_n = quad ? 1'b1 : pin_sync_r[PIN_TWO];

   // ------------------------------------------------------------
   // command classes
   // ------------------------------------------------------------
   wire logic cmd_wr = write_hit(psel, penable, pwrite, paddr, ADDR_COMMAND);
   wire logic cfg_wr = write_hit(psel, penable, pwrite, paddr, ADDR_CONFIG);
   wire logic target_wr = write_hit(psel, penable, pwrite, paddr, ADDR_TARGET);
   wire logic [7:0] cmd = pwdata[7:0];
   wire logic [7:0] cmd_data = pwdata[CMD_DATA_LO +: 8];
   wire logic is_latch_set = cmd == CMD_WRITE_LATCH_SET;
   wire logic is_latch_clr = cmd == CMD_WRITE_LATCH_CLR;
   wire logic is_status_wr = cmd == CMD_STATUS_WRITE;
   wire logic hold_pin_low = !quad && !pin_sync_r[PIN_THREE];
   wire logic reset_selected = vol_param_r[PARAM_RESET_SEL];
   wire logic latch = status_r[SR_LATCH];
   wire logic sr_locked = status_r[SR_LOCK] && !protect_pin_n;

   op_class_type op;
   always_comb begin
      case (cmd)
         CMD_PAGE_PROGRAM: op = OP_PROGRAM;
         CMD_SECTOR_ERASE: op = OP_PROGRAM;
         CMD_BLOCK_ERASE: op = OP_PROGRAM;
         CMD_CHIP_ERASE_A: op = OP_PROGRAM;
         CMD_CHIP_ERASE_B: op = OP_PROGRAM;
         CMD_STATUS_WRITE: op = OP_NVWRITE;
         CMD_FUNC_WRITE: op = OP_NVWRITE;
         CMD_VOL_PARAM: op = OP_NVWRITE;
         CMD_VOL_BANK: op = OP_NVWRITE;
         CMD_VOL_PARAM_ALT: op = OP_OTHER;
         CMD_VOL_BANK_ALT: op = OP_OTHER;
         default: op = OP_NONE;
      endcase
   end

   // ------------------------------------------------------------
   // command decision
   // ------------------------------------------------------------
   logic accept;
   logic deny_prot;
   logic deny_latch;
   logic deny_lock;
   logic is_chip;
   logic vol_status;
   always_comb begin
      is_chip = (cmd == CMD_CHIP_ERASE_A) || (cmd == CMD_CHIP_ERASE_B);
      vol_status = (cmd == CMD_STATUS_WRITE) && vol_enable_r;
      deny_latch = (op != OP_NONE) && (op != OP_OTHER) && !latch && !vol_status;
      deny_prot = 1'b0;
      deny_lock = 1'b0;
      if (is_chip) begin
         deny_prot = code != 4'h0;
      end else if (op == OP_PROGRAM) begin
         deny_prot = in_region(target_r, code, big_r, bottom_r);
      end
      if (cmd == CMD_STATUS_WRITE) begin
         deny_lock = sr_locked;
      end
      accept = !deny_latch && !deny_prot && !deny_lock;
   end

   // ------------------------------------------------------------
   // status register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_r <= SR_RESET;
      end else if (cmd_wr) begin
         if (is_latch_set) begin
            status_r[SR_LATCH] <= 1'b1;
         end else if (is_latch_clr) begin
            status_r[SR_LATCH] <= 1'b0;
         end else if (accept && (op != OP_NONE)) begin
            if (is_status_wr) begin
               status_r[SR_LOCK:SR_CODE_LO] <= cmd_data[SR_LOCK:SR_CODE_LO];
            end
            if (!vol_status && op != OP_OTHER) begin
               status_r[SR_LATCH] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // volatile status write enable: valid for the very next command
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         vol_enable_r <= 1'b0;
      end else if (cmd_wr) begin
         vol_enable_r <= (cmd == CMD_VOLATILE_SR_EN);
      end
   end

   // ------------------------------------------------------------
   // volatile parameter copy updated by alternate commands
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         vol_param_r <= 8'h00;
      end else if (cmd_wr && accept && (op == OP_OTHER)) begin
         vol_param_r <= cmd_data;
      end
   end

   // ------------------------------------------------------------
   // result of last command
   // ------------------------------------------------------------
   logic [4:0] result_nxt;
   always_comb begin
      result_nxt = '0;
      result_nxt[RES_DONE] = 1'b1;
      result_nxt[RES_ACCEPTED] = accept;
      result_nxt[RES_PROTECTED] = deny_prot;
      result_nxt[RES_NO_LATCH] = deny_latch;
      result_nxt[RES_LOCKED] = deny_lock;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         result_r <= 5'h00;
      end else if (cmd_wr) begin
         result_r <= result_nxt;
      end
   end

   // ------------------------------------------------------------
   // configuration and target
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bottom_r <= 1'b0;
      end else if (cfg_wr) begin
         bottom_r <= bottom_r | pwdata[CFG_TOP_BOTTOM];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         big_r <= 1'b0;
      end else if (cfg_wr) begin
         big_r <= pwdata[CFG_BIG_BLOCK];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         target_r <= '0;
      end else if (target_wr) begin
         target_r <= pwdata[ADDR_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // shared pins
   // ------------------------------------------------------------
   always_comb begin
      shared_pin_two_out = quad_data_out[0];
      shared_pin_three_out = quad_data_out[1];
      shared_pin_two_oe = quad && quad_data_oe[0];
      shared_pin_three_oe = quad && quad_data_oe[1];
      quad_data_in = quad ? pin_sync_r : 2'b00;
      hold_active = hold_pin_low && !reset_selected;
      reset_request = hold_pin_low && reset_selected;
   end

   // ------------------------------------------------------------
   // apb answer: ready and error for reads and writes
   // ------------------------------------------------------------
   logic mapped;
   always_comb begin
      mapped = addr_mapped(paddr);
      pready = 1'b1;
      pslverr = psel && penable && !mapped;
   end

   // ------------------------------------------------------------
   // read words
   // ------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] target_word;
   logic [31:0] config_word;
   logic [31:0] result_word;
   logic [31:0] range_word;
   always_comb begin
      status_word = {23'h0, protect_pin_n, status_r};
      target_word = {6'h0, target_r};
      config_word = {30'h0, big_r, bottom_r};
      result_word = {27'h0, result_r};
      range_word = {21'h0, protected_count(code, big_r)};
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_STATUS: prdata <= status_word;
            ADDR_TARGET: prdata <= target_word;
            ADDR_CONFIG: prdata <= config_word;
            ADDR_RESULT: prdata <= result_word;
            ADDR_RANGE: prdata <= range_word;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : flash_block_write_protection
`default_nettype wire

// *** tb/flash_block_write_protection_properties.sv ***
// checker for the write-protection block pins and apb answer
// assumes it is bound into the top module by port name
`timescale 1ns/1ps
`default_nettype none
module wp_checker (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic shared_pin_two_in,
   input wire logic shared_pin_three_in,
   input wire logic shared_pin_two_out,
   input wire logic shared_pin_two_oe,
   input wire logic shared_pin_three_out,
   input wire logic shared_pin_three_oe,
   input wire logic [1:0] quad_data_out,
   input wire logic [1:0] quad_data_oe,
   input wire logic [1:0] quad_data_in,
   input wire logic hold_active,
   input wire logic reset_request
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_ready; psel && penable |-> pready && !$past(penable); endproperty
   a_ready: assert property (p_ready) else $error("apb answer not in one access cycle");
   property p_slverr; pslverr |-> psel && penable; endproperty
   a_slverr: assert property (p_slverr) else $error("error outside access phase");
   property p_two_oe; shared_pin_two_oe |-> quad_data_oe[0] && shared_pin_two_out == quad_data_out[0]; endproperty
   a_two_oe: assert property (p_two_oe) else $error("line two drive wrong");
   property p_three_oe; shared_pin_three_oe |-> quad_data_oe[1] && shared_pin_three_out == quad_data_out[1]; endproperty
   a_three_oe: assert property (p_three_oe) else $error("line three drive wrong");
   property p_hold_excl; !(hold_active && reset_request); endproperty
   a_hold_excl: assert property (p_hold_excl) else $error("hold and reset together");
   property p_pin_roles; hold_active || reset_request |-> !shared_pin_two_oe && !shared_pin_three_oe && quad_data_in == 2'h0;
   endproperty
   a_pin_roles: assert property (p_pin_roles) else $error("pin role mixed with data role");
   property p_hold_pin; hold_active |-> !$past(shared_pin_three_in, 2); endproperty
   a_hold_pin: assert property (p_hold_pin) else $error("hold without low pin");
   property p_quad_in; quad_data_in[1] |-> $past(shared_pin_three_in, 2); endproperty
   a_quad_in: assert property (p_quad_in) else $error("data line three input wrong");
endmodule : wp_checker
bind flash_block_write_protection wp_checker CHK (.*);
`default_nettype wire

// *** tb/pin_board_model.sv ***
// board and host side of the two shared pins
// assumes the bench sets the board levels; the device wins when it drives
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
   input wire logic two_level,
   input wire logic three_level,
   input wire logic two_out,
   input wire logic two_oe,
   input wire logic three_out,
   input wire logic three_oe,
   output logic two_pin,
   output logic three_pin
);
   assign two_pin = two_oe ? two_out : two_level;
   assign three_pin = three_oe ? three_out : three_level;
endmodule : pin_board_model
`default_nettype wire

// *** tb/flash_block_write_protection_tb.sv ***
// self-checking bench for the write-protection block
// assumes the apb map and result codes of the package
`timescale 1ns/1ps
`default_nettype none
module flash_block_write_protection_tb;
   import write_protect_pkg::*;
   logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err, p2, p3, o2, e2, o3, e3, hold_active;
   logic reset_request, lvl2 = 1, lvl3 = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr;
   logic [1:0] qdo = 2'h0, qoe = 2'h0, qdi;
   logic [10:0] tab_s [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 768, 896, 960, 992, 1024};
   logic [10:0] tab_b [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 256, 256, 256, 256, 256, 256, 256};
   localparam logic [3:0] OK = 4'h1, PROT = 4'h2, NOL = 4'h4, LCK = 4'h8;
   int mismatches = 0, num_checks = 0, cycles = 0;
   always #25 core_clk = ~core_clk;
   flash_block_write_protection DUT (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shared_pin_two_in(p2), .shared_pin_three_in(p3), .shared_pin_two_out(o2), .shared_pin_two_oe(e2),
      .shared_pin_three_out(o3), .shared_pin_three_oe(e3), .quad_data_out(qdo), .quad_data_oe(qoe),
      .quad_data_in(qdi), .hold_active(hold_active), .reset_request(reset_request));
   pin_board_model PINS (.two_level(lvl2), .three_level(lvl3), .two_out(o2), .two_oe(e2), .three_out(o3),
      .three_oe(e3), .two_pin(p2), .three_pin(p3));
   task automatic print_verdict;
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
   endtask : apb
   task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic [3:0] e);
      apb(1, ADDR_COMMAND, {16'h0, d, op});
      apb(0, ADDR_RESULT, 0);
      chk(q[4:1], e);
   endtask : cmd
   task automatic setsr(input logic [7:0] v);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_STATUS_WRITE, v, OK);
   endtask : setsr
   task automatic t_codes(input logic big);
      apb(1, ADDR_CONFIG, {30'h0, big, 1'b0});
      for (int c = 0; c < 16; c++) begin
         setsr({2'b00, 4'(c), 2'b00});
         apb(0, ADDR_RANGE, 0);
         chk(q, {21'h0, big ? tab_b[c] : tab_s[c]});
      end
      apb(0, ADDR_STATUS, 0);
      chk(q[1], 0);
   endtask : t_codes
   task automatic t_protect;
      apb(1, ADDR_CONFIG, 0);
      setsr(8'h04);
      apb(1, ADDR_TARGET, 32'h3ff0000);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_PAGE_PROGRAM, 0, PROT);
      apb(1, ADDR_TARGET, 0);
      cmd(CMD_WRITE_LATCH_CLR, 0, OK);
      cmd(CMD_SECTOR_ERASE, 0, NOL);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_BLOCK_ERASE, 0, OK);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_CHIP_ERASE_A, 0, PROT);
      setsr(8'h00);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_CHIP_ERASE_B, 0, OK);
   endtask : t_protect
   task automatic t_lock;
      lvl2 <= 0;
      repeat (3) @(posedge core_clk);
      setsr(8'h80);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_STATUS_WRITE, 8'h00, LCK);
      apb(0, ADDR_STATUS, 0);
      chk(q[7:2], 6'h20);
      lvl2 <= 1;
      repeat (3) @(posedge core_clk);
      cmd(CMD_STATUS_WRITE, 8'h00, OK);
   endtask : t_lock
   task automatic t_volatile;
      cmd(CMD_STATUS_WRITE, 8'h08, NOL);
      cmd(CMD_VOLATILE_SR_EN, 0, OK);
      cmd(CMD_STATUS_WRITE, 8'h08, OK);
      apb(0, ADDR_STATUS, 0);
      chk(q[5:2], 4'h2);
      cmd(CMD_VOL_PARAM_ALT, 8'h00, OK);
      cmd(CMD_VOL_BANK_ALT, 8'h00, OK);
      cmd(CMD_VOL_PARAM, 0, NOL);
      cmd(CMD_FUNC_WRITE, 0, NOL);
      setsr(8'h00);
   endtask : t_volatile
   task automatic t_quad;
      lvl3 <= 0;
      repeat (3) @(posedge core_clk);
      chk(hold_active, 1);
      cmd(CMD_VOL_PARAM_ALT, 8'h80, OK);
      chk({hold_active, reset_request}, 2'b01);
      setsr(8'h40);
      chk(reset_request, 0);
      qoe <= 2'b11;
      qdo <= 2'b10;
      @(posedge core_clk);
      chk({e3, e2, p3, p2}, 4'b1110);
      qoe <= 2'b00;
      lvl2 <= 0;
      lvl3 <= 1;
      repeat (3) @(posedge core_clk);
      chk(qdi, 2'b10);
      apb(0, ADDR_STATUS, 0);
      chk(q[8], 1);
      lvl2 <= 1;
      setsr(8'h00);
   endtask : t_quad
   task automatic t_bottom;
      apb(1, ADDR_CONFIG, 1);
      setsr(8'h38);
      apb(0, ADDR_RANGE, 0);
      chk(q, 992);
      apb(1, ADDR_TARGET, 32'h3df0000);
      cmd(CMD_WRITE_LATCH_SET, 0, OK);
      cmd(CMD_PAGE_PROGRAM, 0, PROT);
      apb(1, ADDR_TARGET, 32'h3e00000);
      cmd(CMD_PAGE_PROGRAM, 0, OK);
      apb(1, ADDR_CONFIG, 0);
      apb(0, ADDR_CONFIG, 0);
      chk(q[0], 1);
   endtask : t_bottom
   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 0;
      @(posedge core_clk);
      apb(0, ADDR_STATUS, 0);
      chk(q[7:0], 8'h00);
      apb(0, ADDR_CONFIG, 0);
      chk(q[1:0], 2'b00);
      apb(0, 8'h3c, 0);
      chk(err, 1);
      t_codes(0);
      t_codes(1);
      t_protect();
      t_lock();
      t_volatile();
      t_quad();
      t_bottom();
      print_verdict();
   end
endmodule : flash_block_write_protection_tb
`default_nettype wire
